// File: haptic_control_and_fifo_regs.sv
// Functional notes
// - Soft reset bit restores defaults, enters standby
// - Standby bit defaults one, clear means active
// - Idle after empty FIFO timeout, 5-20 ms
// - Override keeps boost and amplifier enabled outside standby
// - Each entry write taken while entry ready pushes next waveform byte
// - Control fields reachable through register accesses; FIFO full/empty flags only on the o_fifo_full/o_fifo_empty pins
// - 100-byte FIFO refuses when full, flags states; entry writes are refused only once the two-entry buffer also fills
`timescale 1ns/10ps
module haptic_control_and_fifo_regs
   import haptic_regs_pkg::*;
#(
   parameter int unsigned P_TIMEOUT_STEP_CYC = TIMEOUT_STEP_CYC
)(
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_entry_ready,
   output logic o_sample_valid,
   output logic [7:0] o_sample_data,
   input wire logic i_sample_ready,
   output logic o_boost_en,
   output logic o_amp_en,
   output logic o_standby,
   output logic o_fifo_full,
   output logic o_fifo_empty
);
   logic soft_rst_reg;
   logic clear_all;
   logic standby_reg;
   logic [1:0] timeout_reg;
   logic override_reg;
   logic [7:0] entry_reg;
   logic [7:0] rdata_reg;
   logic [7:0] fifo_reg [FIFO_DEPTH];
   logic [6:0] wr_idx_reg;
   logic [6:0] rd_idx_reg;
   logic [6:0] count_reg;
   logic [6:0] count_next;
   logic full_reg;
   logic empty_reg;
   logic sample_valid_reg;
   logic [7:0] sample_data_reg;
   logic boost_reg;
   logic [31:0] idle_cnt_reg;
   logic [31:0] idle_limit;
   play_state_t state_reg;
   logic wr_ctrl;
   logic wr_entry;
   logic pull;
   logic pop;
   logic [7:0] ctrl_view;

   byte_stream_if host_side ();
   byte_stream_if fifo_side ();

   // Soft reset acts one cycle after the write, so the write itself completes
   assign clear_all = i_reset || soft_rst_reg;
   assign wr_ctrl = i_wr_en && (i_addr == ADDR_CTRL);
   assign wr_entry = i_wr_en && (i_addr == ADDR_ENTRY);
   assign ctrl_view = {1'b0, standby_reg, 2'b00, timeout_reg, override_reg, 1'b0};

   // Two-entry buffer absorbs a byte while the main FIFO is busy
   assign host_side.valid = wr_entry;
   assign host_side.data = i_wdata;
   entry_skid_buffer entry_skid_buffer_i (
      .i_mclk(i_mclk),
      .i_clear(clear_all),
      .fill(host_side.snk),
      .drain(fifo_side.src)
   );

   // Main FIFO takes from the buffer only while not full
   assign pull = fifo_side.valid && !full_reg;
   assign fifo_side.ready = !full_reg;
   // No pop once standby is set: the pending sample is dropped then, so a byte would be lost
   assign pop = (count_reg != 7'h00) && (!sample_valid_reg || i_sample_ready)
      && (state_reg == ST_PLAY) && !standby_reg;
   assign idle_limit = 32'(({30'h0, timeout_reg} + 32'h1) * P_TIMEOUT_STEP_CYC);

   always_comb begin
      count_next = count_reg + {6'h0, pull} - {6'h0, pop};
   end

   // Soft reset pulse; the bit never reads back as one
   always_ff @(posedge i_mclk) begin
      if (clear_all) begin
         soft_rst_reg <= 1'b0;
      end else begin
         soft_rst_reg <= wr_ctrl && i_wdata[SOFT_RESET_BIT];
      end
   end

   // Control fields; reserved bits are simply not stored
   always_ff @(posedge i_mclk) begin
      if (clear_all) begin
         standby_reg <= STANDBY_RST;
         timeout_reg <= TIMEOUT_RST;
         override_reg <= OVERRIDE_RST;
      end else if (wr_ctrl) begin
         standby_reg <= i_wdata[STANDBY_BIT];
         timeout_reg <= i_wdata[TIMEOUT_MSB:TIMEOUT_LSB];
         override_reg <= i_wdata[OVERRIDE_BIT];
      end
   end

   // Entry register keeps the last byte offered, accepted or not
   always_ff @(posedge i_mclk) begin
      if (clear_all) begin
         entry_reg <= ENTRY_RST;
      end else if (wr_entry) begin
         entry_reg <= i_wdata;
      end
   end

   // Read data, one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge i_mclk) begin
      if (clear_all) begin
         rdata_reg <= 8'h00;
      end else if (i_rd_en) begin
         if (i_addr == ADDR_CTRL) begin
            rdata_reg <= ctrl_view;
         end else if (i_addr == ADDR_ENTRY) begin
            rdata_reg <= entry_reg;
         end else begin
            rdata_reg <= 8'h00;
         end
      end
   end

   // FIFO storage, indexed ring
   always_ff @(posedge i_mclk) begin
      if (pull) begin
         fifo_reg[wr_idx_reg] <= fifo_side.data;
      end
   end

   // FIFO pointers and flags; flags are registered from the next count
   always_ff @(posedge i_mclk) begin
      if (clear_all) begin
         wr_idx_reg <= 7'h00;
         rd_idx_reg <= 7'h00;
         count_reg <= 7'h00;
         full_reg <= 1'b0;
         empty_reg <= 1'b1;
      end else begin
         if (pull) begin
            wr_idx_reg <= (wr_idx_reg == FIFO_FULL_COUNT - 7'h01) ? 7'h00 : wr_idx_reg + 7'h01;
         end
         if (pop) begin
            rd_idx_reg <= (rd_idx_reg == FIFO_FULL_COUNT - 7'h01) ? 7'h00 : rd_idx_reg + 7'h01;
         end
         count_reg <= count_next;
         full_reg <= (count_next == FIFO_FULL_COUNT);
         empty_reg <= (count_next == 7'h00);
      end
   end

   // Sample handed to the DAC side with valid and ready
   always_ff @(posedge i_mclk) begin
      if (clear_all) begin
         sample_valid_reg <= 1'b0;
         sample_data_reg <= 8'h00;
      end else if (standby_reg) begin
         sample_valid_reg <= 1'b0;
      end else if (pop) begin
         sample_valid_reg <= 1'b1;
         sample_data_reg <= fifo_reg[rd_idx_reg];
      end else if (i_sample_ready) begin
         sample_valid_reg <= 1'b0;
      end
   end

   // Play sequencing: data wakes the device, an empty FIFO starts the idle timer
   always_ff @(posedge i_mclk) begin
      if (clear_all || standby_reg) begin
         state_reg <= ST_STANDBY;
         idle_cnt_reg <= 32'h0;
      end else begin
         unique case (state_reg)
            ST_STANDBY: begin
               state_reg <= ST_IDLE;
            end
            ST_IDLE: begin
               if (!empty_reg) begin
                  state_reg <= ST_PLAY;
               end
            end
            ST_PLAY: begin
               idle_cnt_reg <= 32'h0;
               if (empty_reg && !sample_valid_reg) begin
                  state_reg <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (!empty_reg) begin
                  state_reg <= ST_PLAY;
               end else if (idle_cnt_reg >= idle_limit - 32'h1) begin
                  state_reg <= ST_IDLE;
               end else begin
                  idle_cnt_reg <= idle_cnt_reg + 32'h1;
               end
            end
         endcase
      end
   end

   // Power enables; standby wins over the override to keep low power honest
   always_ff @(posedge i_mclk) begin
      if (clear_all) begin
         boost_reg <= 1'b0;
      end else begin
         boost_reg <= !standby_reg && (override_reg || state_reg == ST_PLAY
            || state_reg == ST_DRAIN);
      end
   end

   assign o_rdata = rdata_reg;
   assign o_entry_ready = host_side.ready;
   assign o_sample_valid = sample_valid_reg;
   assign o_sample_data = sample_data_reg;
   assign o_boost_en = boost_reg;
   assign o_amp_en = boost_reg;
   assign o_standby = standby_reg;
   assign o_fifo_full = full_reg;
   assign o_fifo_empty = empty_reg;

   AST_SOFT_RESET: assert property (@(posedge i_mclk) disable iff (i_reset)
      wr_ctrl && i_wdata[SOFT_RESET_BIT] |=> ##1 (standby_reg && empty_reg && !boost_reg
      && entry_reg == ENTRY_RST && timeout_reg == TIMEOUT_RST))
      else $error("soft reset did not restore defaults");
   AST_STANDBY_QUIET: assert property (@(posedge i_mclk) disable iff (i_reset)
      standby_reg [*2] |-> !o_boost_en && !o_sample_valid ##0 state_reg == ST_STANDBY)
      else $error("activity while in standby");
   AST_IDLE_TIMEOUT: assert property (@(posedge i_mclk) disable iff (i_reset)
      state_reg == ST_DRAIN && empty_reg && !standby_reg && !soft_rst_reg
      && idle_cnt_reg == idle_limit - 32'h1 |=> state_reg == ST_IDLE)
      else $error("idle timeout not honoured");
   AST_OVERRIDE_ON: assert property (@(posedge i_mclk) disable iff (i_reset)
      override_reg && !standby_reg && !soft_rst_reg |=> o_boost_en && o_amp_en)
      else $error("override did not hold enables");
   AST_ENTRY_PUSH: assert property (@(posedge i_mclk) disable iff (i_reset)
      wr_entry && o_entry_ready && !soft_rst_reg |=> entry_reg == $past(i_wdata)
      && fifo_side.valid)
      else $error("entry write not taken");
   AST_CTRL_READ: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_rd_en && i_addr == ADDR_CTRL && !wr_ctrl && !soft_rst_reg |=> o_rdata == $past(ctrl_view))
      else $error("control read mismatch");
   AST_FIFO_FULL: assert property (@(posedge i_mclk) disable iff (i_reset)
      (o_fifo_full == (count_reg == FIFO_FULL_COUNT)) && (o_fifo_empty == (count_reg == 7'h00))
      && !(full_reg && pull) && (count_reg <= FIFO_FULL_COUNT))
      else $error("FIFO flags or refusal wrong");
   AST_RESERVED_ZERO: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_rd_en && i_addr == ADDR_CTRL |=> o_rdata[5:4] == 2'b00 && !o_rdata[0] && !o_rdata[7])
      else $error("reserved control bits not zero");
endmodule

// File: haptic_regs_pkg.sv
package haptic_regs_pkg;
   // Register map
   localparam logic [7:0] ADDR_CTRL = 8'h02;
   localparam logic [7:0] ADDR_ENTRY = 8'h0B;
   // Control register field positions
   localparam int SOFT_RESET_BIT = 7;
   localparam int STANDBY_BIT = 6;
   localparam int TIMEOUT_LSB = 2;
   localparam int TIMEOUT_MSB = 3;
   localparam int OVERRIDE_BIT = 1;
   // Values after reset
   localparam logic STANDBY_RST = 1'h1;
   localparam logic [1:0] TIMEOUT_RST = 2'h0;
   localparam logic OVERRIDE_RST = 1'h0;
   localparam logic [7:0] ENTRY_RST = 8'h00;
   // Storage sizes
   localparam int FIFO_DEPTH = 100;
   localparam logic [6:0] FIFO_FULL_COUNT = 7'h64;
   localparam int SKID_DEPTH = 2;
   // Timing: one timeout step, counted at the master clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int TIMEOUT_STEP_MS = 5;
   localparam int TIMEOUT_STEP_CYC = TIMEOUT_STEP_MS * 1000000 / CLK_PERIOD_NS;
   typedef enum logic [1:0] {ST_STANDBY, ST_IDLE, ST_PLAY, ST_DRAIN} play_state_t;
endpackage

// File: byte_stream_if.sv
`timescale 1ns/10ps
interface byte_stream_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface

// File: entry_skid_buffer.sv
`timescale 1ns/10ps
module entry_skid_buffer
   import haptic_regs_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_clear,
   byte_stream_if.snk fill,
   byte_stream_if.src drain
);
   logic [7:0] mem_reg [SKID_DEPTH];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   logic [1:0] count_next;
   logic ready_reg;
   logic push;
   logic pop;

   // Ready is held in a flop so the filling side never sees a combinational path
   assign push = fill.valid && ready_reg;
   assign pop = drain.valid && drain.ready;
   assign drain.valid = (count_reg != 2'h0);
   assign drain.data = mem_reg[rd_ptr_reg];
   assign fill.ready = ready_reg;

   always_comb begin
      count_next = count_reg + {1'b0, push} - {1'b0, pop};
   end

   // Storage write
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= fill.data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge i_mclk) begin
      if (i_clear) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
         ready_reg <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_next;
         ready_reg <= (count_next != 2'h2);
      end
   end
endmodule

// File: haptic_sample_sink.sv
`timescale 1ns/10ps
module haptic_sample_sink (
   input wire logic i_mclk,
   input wire logic i_stall_en,
   input wire logic i_valid,
   input wire logic [7:0] i_data,
   output logic o_ready
);
   logic [7:0] got[$];
   logic phase_reg = 1'h0;
   // Refuse every other cycle while stalling, so the design must hold its sample
   always @(posedge i_mclk) begin
      phase_reg <= ~phase_reg;
      if (i_valid && o_ready) begin
         got.push_back(i_data);
      end
   end
   // Ready only moves just after an edge
   assign o_ready = i_stall_en ? phase_reg : 1'h1;
endmodule

// File: haptic_control_and_fifo_regs_test.sv
`timescale 1ns/10ps
module haptic_control_and_fifo_regs_test
   import haptic_regs_pkg::*;
;
   localparam int STEP = 20;
   logic mclk = 1'h0;
   logic reset = 1'h1;
   logic wr_en = 1'h0;
   logic rd_en = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic stall_en = 1'h0;
   logic [7:0] rdata;
   logic entry_ready, sample_valid, sample_ready, boost_en, amp_en;
   logic standby, fifo_full, fifo_empty;
   logic [7:0] sample_data;
   int n_fail = 0;
   int tests_run = 0;
   int n;

   always #5 mclk = ~mclk;

   haptic_control_and_fifo_regs #(.P_TIMEOUT_STEP_CYC(STEP)) haptic_control_and_fifo_regs_i (
      .i_mclk(mclk), .i_reset(reset), .i_wr_en(wr_en), .i_rd_en(rd_en),
      .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_entry_ready(entry_ready),
      .o_sample_valid(sample_valid), .o_sample_data(sample_data),
      .i_sample_ready(sample_ready), .o_boost_en(boost_en), .o_amp_en(amp_en),
      .o_standby(standby), .o_fifo_full(fifo_full), .o_fifo_empty(fifo_empty));

   haptic_sample_sink haptic_sample_sink_i (.i_mclk(mclk), .i_stall_en(stall_en),
      .i_valid(sample_valid), .i_data(sample_data), .o_ready(sample_ready));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One-cycle strobe; the leading wait keeps two calls from touching wr_en in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      wr_en = 1'h1;
      addr = a;
      wdata = d;
      @(negedge mclk);
      wr_en = 1'h0;
   endtask

   // Read data lands on the edge after the strobe and is settled at the next fall
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge mclk);
      rd_en = 1'h1;
      addr = a;
      @(negedge mclk);
      rd_en = 1'h0;
      check(rdata, exp, what);
   endtask

   task automatic idle(input int k);
      repeat (k) @(negedge mclk);
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Whole run is under a thousand cycles; this is a generous ceiling
   initial begin
      #200000;
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      idle(4);
      reset = 1'h0;
      rd(ADDR_CTRL, 8'h40, "ctrl default");
      rd(ADDR_ENTRY, 8'h00, "entry default");
      check({7'h00, standby}, 8'h01, "standby after reset");
      check({6'h00, fifo_full, fifo_empty}, 8'h01, "flags after reset");
      check({6'h00, boost_en, amp_en}, 8'h00, "enables after reset");
      rd(8'h05, 8'h00, "unmapped read");
      wr(ADDR_CTRL, 8'h3D);
      rd(ADDR_CTRL, 8'h0C, "reserved bits");
      // Byte stored in standby must vanish with the soft reset
      wr(ADDR_CTRL, 8'h4E);
      wr(ADDR_ENTRY, 8'hA5);
      idle(3);
      check({7'h00, fifo_empty}, 8'h00, "stored in standby");
      wr(ADDR_CTRL, 8'hCE);
      idle(3);
      rd(ADDR_CTRL, 8'h40, "ctrl after soft reset");
      rd(ADDR_ENTRY, 8'h00, "entry after soft reset");
      check({6'h00, fifo_empty, standby}, 8'h03, "fifo after soft reset");
      // Override holds enables far beyond any idle timer
      wr(ADDR_CTRL, 8'h02);
      idle(3);
      check({6'h00, boost_en, amp_en}, 8'h03, "override on");
      idle(5 * STEP);
      check({6'h00, boost_en, amp_en}, 8'h03, "override holds");
      wr(ADDR_CTRL, 8'h42);
      idle(3);
      check({6'h00, boost_en, amp_en}, 8'h00, "standby beats override");
      // Idle timeout for every code, counted from the last sample taken
      wr(ADDR_CTRL, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_CTRL, {4'h0, c[1:0], 2'h0});
         wr(ADDR_ENTRY, 8'h10 + c[7:0]);
         n = 0;
         while (haptic_sample_sink_i.got.size() < c + 1 && n < 50) begin
            @(negedge mclk);
            n++;
         end
         check(haptic_sample_sink_i.got[c], 8'h10 + c[7:0], "played byte");
         check({6'h00, boost_en, amp_en}, 8'h03, "enables while playing");
         n = 0;
         while (boost_en === 1'h1 && n < 200) begin
            @(negedge mclk);
            n++;
         end
         check({7'h00, n >= (c + 1) * STEP - 1 && n <= (c + 1) * STEP + 4}, 8'h01,
            "idle timeout");
      end
      // Fill in standby past the limit; the last write must be refused
      wr(ADDR_CTRL, 8'h40);
      stall_en = 1'h1;
      haptic_sample_sink_i.got.delete();
      for (int i = 0; i < 103; i++) begin
         wr(ADDR_ENTRY, i[7:0]);
      end
      idle(3);
      check({6'h00, fifo_full, entry_ready}, 8'h02, "full and refusing");
      rd(ADDR_ENTRY, 8'h66, "entry readback");
      // Drain with a stalling receiver; nothing accepted may be lost
      wr(ADDR_CTRL, 8'h00);
      n = 0;
      while (haptic_sample_sink_i.got.size() < 102 && n < 1000) begin
         @(negedge mclk);
         n++;
      end
      idle(5);
      check(haptic_sample_sink_i.got.size(), 8'h66, "drained count");
      for (int i = 0; i < 102; i++) begin
         check(haptic_sample_sink_i.got[i], i[7:0], "stream order");
      end
      check({6'h00, fifo_full, fifo_empty}, 8'h01, "empty after drain");
      report_and_stop();
   end
endmodule
